// ---- src/opc_pkg.sv ----
package opc_pkg;
	// ************************************************
	// Register byte offsets on the APB
	// ************************************************
	localparam logic [7:0] ADDR_CTRL4 = 8'h00;
	localparam logic [7:0] ADDR_OUTCTL = 8'h04;
	localparam logic [7:0] ADDR_PWMDUTY = 8'h08;
	localparam logic [7:0] ADDR_SUPPLY = 8'h0C;
	localparam logic [7:0] ADDR_DRVSTAT = 8'h10;
	localparam logic [7:0] ADDR_THERM = 8'h14;
	localparam logic [7:0] ADDR_OUTSTATE = 8'h18;

	// ************************************************
	// Field positions
	// ************************************************
	localparam int CTRL_LOCK = 0;
	localparam int CTRL_RELAY_SD = 1;
	localparam int CTRL_HS_REC = 2;
	localparam int CTRL_FSO_MODE = 3;
	localparam int OUTCTL_EN_LSB = 0;
	localparam int OUTCTL_REL_LSB = 5;
	localparam int OUTCTL_SEL1 = 8;
	localparam int OUTCTL_SEL2 = 9;
	localparam int OUTCTL_SEL4 = 10;
	localparam int OUTCTL_HSSRC_LSB = 12;
	localparam int SUP_OV = 0;
	localparam int SUP_UV = 1;
	localparam int DRV_OC_LSB = 0;
	localparam int DRV_OT_LSB = 8;
	localparam int DRV_OL_LSB = 16;
	localparam int OUT3_IDX = 2;
	localparam int HS_IDX = 4;

	// ************************************************
	// Reset values
	// ************************************************
	localparam logic [3:0] CTRL4_RST = 4'h0;
	localparam logic [13:0] OUTCTL_RST = 14'h0000;
	localparam logic [13:0] OUT3_KEEP_MASK = 14'h0004;
	localparam logic [31:0] PWMDUTY_RST = 32'h00000000;

	// ************************************************
	// Timing
	// ************************************************
	localparam int CLK_NS = 40;
	localparam int RECOVER_NS = 1000;
	localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
	localparam int SYNC_W = 17;

	// Gray coded along normal -> warning -> stage one -> stage two
	typedef enum logic [1:0] {
		TH_NORMAL = 2'b00,
		TH_WARN = 2'b01,
		TH_STAGE1 = 2'b11,
		TH_STAGE2 = 2'b10
	} opc_therm_e;
endpackage

// ---- src/opc_pwm_chan.sv ----
`timescale 1ns/1ps
module opc_pwm_chan #(
	parameter int CNT_W = 8,
	parameter bit START_ON = 1'b1
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Async reset, active low
	input wire logic [CNT_W-1:0] duty, // On counts per period
	output logic pwm // Channel output
);
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] off_start;

	// All channels leave reset together, so their periods stay aligned
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	assign off_start = CNT_W'(~duty + 1'b1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm <= 1'b0;
		end else if (START_ON) begin
			pwm <= (cnt_r < duty);
		end else begin
			pwm <= (duty != '0) && (cnt_r >= off_start);
		end
	end
endmodule

// ---- src/opc_output_protection.sv ----
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
module opc_output_protection #(
	parameter int PWM_W = 8,
	parameter int RECOVER_CYC = opc_pkg::RECOVER_CYC
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Async reset, active low
	input wire logic [7:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic supply_ov_in, // Supply above overvoltage threshold
	input wire logic supply_uv_in, // Supply below undervoltage threshold
	input wire logic [4:0] overcurrent_in, // Per driver overcurrent
	input wire logic [4:0] open_load_in, // Per driver open load
	input wire logic thermal_warn_in, // Temperature pre-warning
	input wire logic thermal_stage_one_in, // First shutdown stage
	input wire logic thermal_stage_two_in, // Second shutdown stage
	input wire logic standby_in, // Device in standby
	input wire logic failsafe_in, // Device in failsafe
	input wire logic timer1_in, // Internal timer 1, pclk domain
	input wire logic timer2_in, // Internal timer 2, pclk domain
	output logic [4:0] highside_outputs, // Out1..4, bit 4 strong output
	output logic [1:0] relay_outputs, // Relay drivers
	output logic lin_output_enable, // Low puts LIN output to high impedance
	output logic [1:0] thermal_state // Thermal state code
);
	// ************************************************
	// Input synchronisers
	// ************************************************
	logic [opc_pkg::SYNC_W-1:0] sync1_r;
	logic [opc_pkg::SYNC_W-1:0] sync_r;
	logic ov_s, uv_s, warn_s, thermal_stage_one_s, thermal_stage_two_s, stby_s, fs_s;
	logic [4:0] oc_s, ol_s;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r <= '0;
			sync_r <= '0;
		end else begin
			sync1_r <= {supply_ov_in, supply_uv_in, overcurrent_in, open_load_in, thermal_warn_in,
				thermal_stage_one_in, thermal_stage_two_in, standby_in, failsafe_in};
			sync_r <= sync1_r;
		end
	end

	assign {ov_s, uv_s, oc_s, ol_s, warn_s, thermal_stage_one_s, thermal_stage_two_s, stby_s, fs_s} = sync_r;

	// ************************************************
	// APB slave
	// ************************************************
	logic [3:0] ctrl4_r;
	logic [13:0] outctl_r;
	logic [31:0] duty_r;
	logic [1:0] sup_r;
	logic [4:0] oc_r, ot_r, ol_r;
	opc_pkg::opc_therm_e therm_r;
	logic [4:0] hs_out_nxt;
	logic [1:0] rel_nxt;
	logic supply_off;
	logic setup, done, wr, rd_sup, w1c;
	logic [31:0] rdata_nxt;
	logic known;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	assign setup = psel && !penable;
	assign done = psel && penable && pready;
	assign wr = done && pwrite && !pslverr;
	assign rd_sup = done && !pwrite && hit(paddr, opc_pkg::ADDR_SUPPLY);
	assign w1c = wr && hit(paddr, opc_pkg::ADDR_DRVSTAT);

	always_comb begin
		rdata_nxt = 32'h00000000;
		known = 1'b1;
		unique case (paddr)
			opc_pkg::ADDR_CTRL4: rdata_nxt[3:0] = ctrl4_r;
			opc_pkg::ADDR_OUTCTL: rdata_nxt[13:0] = outctl_r;
			opc_pkg::ADDR_PWMDUTY: rdata_nxt = duty_r;
			opc_pkg::ADDR_SUPPLY: rdata_nxt[1:0] = sup_r;
			opc_pkg::ADDR_DRVSTAT: begin
				rdata_nxt[opc_pkg::DRV_OC_LSB +: 5] = oc_r;
				rdata_nxt[opc_pkg::DRV_OT_LSB +: 5] = ot_r;
				rdata_nxt[opc_pkg::DRV_OL_LSB +: 5] = ol_r;
			end
			opc_pkg::ADDR_THERM: rdata_nxt[2:0] = {stby_s, therm_r};
			opc_pkg::ADDR_OUTSTATE: rdata_nxt[7:0] = {lin_output_enable, relay_outputs, highside_outputs};
			default: known = 1'b0;
		endcase
	end

	// No wait state: data is captured in setup, answered in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup;
			if (setup) begin
				pslverr <= !known;
				prdata <= rdata_nxt;
			end else if (done) begin
				pslverr <= 1'b0;
			end
		end
	end

	// ************************************************
	// Control registers
	// ************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl4_r <= opc_pkg::CTRL4_RST;
			duty_r <= opc_pkg::PWMDUTY_RST;
		end else if (wr) begin
			if (hit(paddr, opc_pkg::ADDR_CTRL4)) begin
				ctrl4_r <= pwdata[3:0];
			end
			if (hit(paddr, opc_pkg::ADDR_PWMDUTY)) begin
				duty_r <= pwdata;
			end
		end
	end

	// Failsafe holds driver control at default, except the OUT3 enable in FSO mode, so writes during it are lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			outctl_r <= opc_pkg::OUTCTL_RST;
		end else if (fs_s) begin
			outctl_r <= opc_pkg::OUTCTL_RST |
				(ctrl4_r[opc_pkg::CTRL_FSO_MODE] ? (outctl_r & opc_pkg::OUT3_KEEP_MASK) : 14'h0000);
		end else if (wr && hit(paddr, opc_pkg::ADDR_OUTCTL)) begin
			outctl_r <= pwdata[13:0];
		end
	end

	// ************************************************
	// Supply fault status
	// ************************************************
	logic [1:0] sup_cond;
	assign sup_cond = {uv_s, ov_s};

	// A fault present in the clearing cycle sets the bit again
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sup_r <= 2'b00;
		end else begin
			sup_r <= sup_cond | (sup_r & ~{2{rd_sup}} &
				~({2{!ctrl4_r[opc_pkg::CTRL_LOCK]}} & ~sup_cond));
		end
	end

	// Unlocked bits drop with the fault, so this covers both recovery styles
	assign supply_off = (|sup_r) || ov_s || uv_s;

	// ************************************************
	// Driver faults
	// ************************************************
	logic stage_hot;
	logic [4:0] ot_exempt;
	logic [4:0] oc_set;
	logic [$clog2(RECOVER_CYC+1)-1:0] retry_r;
	logic rec_en;

	assign rec_en = ctrl4_r[opc_pkg::CTRL_HS_REC];
	assign stage_hot = (therm_r == opc_pkg::TH_STAGE1) || (therm_r == opc_pkg::TH_STAGE2);
	assign ot_exempt = {2'b00, ctrl4_r[opc_pkg::CTRL_FSO_MODE], 2'b00};
	assign oc_set = oc_s & ~{rec_en, 4'h0};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oc_r <= 5'h00;
		end else begin
			oc_r <= oc_set | (oc_r & ~({5{w1c}} & pwdata[opc_pkg::DRV_OC_LSB +: 5]));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ot_r <= 5'h00;
		end else begin
			ot_r <= ({5{stage_hot}} & ~ot_exempt) |
				(ot_r & ~({5{w1c}} & pwdata[opc_pkg::DRV_OT_LSB +: 5]));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ol_r <= 5'h00;
		end else begin
			ol_r <= ol_s | (ol_r & ~({5{w1c}} & pwdata[opc_pkg::DRV_OL_LSB +: 5]));
		end
	end

	// Strong output is held off for a fixed interval, then tried again
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			retry_r <= '0;
		end else if (rec_en && oc_s[opc_pkg::HS_IDX] && (retry_r == '0)) begin
			retry_r <= ($clog2(RECOVER_CYC+1))'(RECOVER_CYC);
		end else if (retry_r != '0) begin
			retry_r <= retry_r - 1'b1;
		end
	end

	// ************************************************
	// Thermal state machine
	// ************************************************
	logic stby_d_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stby_d_r <= 1'b0;
		end else begin
			stby_d_r <= stby_s;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			therm_r <= opc_pkg::TH_NORMAL;
		end else if (stby_s) begin
			therm_r <= therm_r;
		end else if (stby_d_r) begin
			therm_r <= (therm_r == opc_pkg::TH_STAGE2) ? opc_pkg::TH_STAGE1 : therm_r;
		end else if (thermal_stage_two_s) begin
			therm_r <= opc_pkg::TH_STAGE2;
		end else if (thermal_stage_one_s) begin
			therm_r <= opc_pkg::TH_STAGE1;
		end else if (warn_s) begin
			therm_r <= opc_pkg::TH_WARN;
		end else begin
			therm_r <= opc_pkg::TH_NORMAL;
		end
	end

	// ************************************************
	// PWM channels and source selection
	// ************************************************
	logic [3:0] pwm;
	logic [4:0] src;

	for (genvar i = 0; i < 4; i++) begin : g_pwm
		opc_pwm_chan #(
			.CNT_W(PWM_W),
			.START_ON((i % 2) == 0)
		) u_pwm (
			.pclk(pclk),
			.presetn(presetn),
			.duty(duty_r[i*8 +: PWM_W]),
			.pwm(pwm[i])
		);
	end

	always_comb begin
		src[0] = outctl_r[opc_pkg::OUTCTL_SEL1] ? timer1_in : pwm[0];
		src[1] = outctl_r[opc_pkg::OUTCTL_SEL2] ? timer2_in : pwm[1];
		src[2] = pwm[2];
		src[3] = outctl_r[opc_pkg::OUTCTL_SEL4] ? timer2_in : pwm[3];
		unique case (outctl_r[opc_pkg::OUTCTL_HSSRC_LSB +: 2])
			2'd0: src[4] = pwm[2];
			2'd1: src[4] = pwm[3];
			2'd2: src[4] = timer1_in;
			2'd3: src[4] = timer2_in;
		endcase
	end

	// ************************************************
	// Output drivers
	// ************************************************
	logic [4:0] hs_kill;

	always_comb begin
		// The synced overcurrent acts at once so the driver drops three clocks after the pin rises
		hs_kill = oc_r | oc_set | ot_r | {5{supply_off}};
		hs_kill[opc_pkg::HS_IDX] = hs_kill[opc_pkg::HS_IDX] || (retry_r != '0) ||
			(rec_en && oc_s[opc_pkg::HS_IDX]);
		hs_out_nxt = outctl_r[opc_pkg::OUTCTL_EN_LSB +: 5] & src & ~hs_kill;
		rel_nxt = outctl_r[opc_pkg::OUTCTL_REL_LSB +: 2] &
			~{2{supply_off && ctrl4_r[opc_pkg::CTRL_RELAY_SD]}};
	end

	// Registered once after the synchroniser: supply or overcurrent fault to output in three clocks, thermal stage in five
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			highside_outputs <= 5'h00;
			relay_outputs <= 2'b00;
			lin_output_enable <= 1'b0;
			thermal_state <= 2'b00;
		end else begin
			highside_outputs <= hs_out_nxt;
			relay_outputs <= rel_nxt;
			lin_output_enable <= !supply_off;
			thermal_state <= therm_r;
		end
	end
endmodule

// ---- tb/opc_protect_assertions.sv ----
`timescale 1ns/1ps
module opc_protect_chk (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire logic supply_ov_in, // Overvoltage
	input wire logic supply_uv_in, // Undervoltage
	input wire logic [4:0] overcurrent_in, // Overcurrent
	input wire logic thermal_stage_one_in, // Stage one
	input wire logic standby_in, // Standby
	input wire logic [4:0] highside_outputs, // Drivers
	input wire logic lin_output_enable, // LIN enable
	input wire logic [1:0] thermal_state // Thermal code
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ****
	// Properties
	// ****
	// Fault pins need two sync edges plus the output register
	sequence s_sup; (supply_ov_in || supply_uv_in)[*3]; endsequence
	sequence s_oc_gone; overcurrent_in[0][*3] ##1 (!overcurrent_in[0] && !psel)[*5]; endsequence
	property p_setup; psel && !penable |=> pready; endproperty
	property p_pulse; pready |=> !pready; endproperty
	property p_err; pslverr |-> pready; endproperty
	property p_sup_off; s_sup |=> highside_outputs == 5'h00 && !lin_output_enable; endproperty
	property p_oc_off; overcurrent_in[0][*3] |=> !highside_outputs[0]; endproperty
	property p_oc_hold; s_oc_gone |-> !highside_outputs[0]; endproperty
	property p_ot_off; (thermal_stage_one_in && !standby_in)[*5] |=> (highside_outputs & 5'h1B) == 5'h00; endproperty
	property p_frozen; standby_in[*4] |=> $stable(thermal_state); endproperty
	a_setup: assert property (p_setup) else $error("no ready after setup");
	a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
	a_err: assert property (p_err) else $error("error without ready");
	a_sup_off: assert property (p_sup_off) else $error("outputs on in supply fault");
	a_oc_off: assert property (p_oc_off) else $error("driver on in overcurrent");
	a_oc_hold: assert property (p_oc_hold) else $error("driver back before clear");
	a_ot_off: assert property (p_ot_off) else $error("driver on in stage one");
	a_frozen: assert property (p_frozen) else $error("thermal state moved in standby");
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	localparam logic [7:0] CT = opc_pkg::ADDR_CTRL4;
	localparam logic [7:0] OC = opc_pkg::ADDR_OUTCTL;
	localparam logic [7:0] DS = opc_pkg::ADDR_DRVSTAT;
	localparam logic [7:0] SU = opc_pkg::ADDR_SUPPLY;
	localparam logic [31:0] ON = 32'h0000277F;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, seen, lin_output_enable;
	logic supply_ov_in = 1'b0, supply_uv_in = 1'b0, thermal_warn_in = 1'b0, standby_in = 1'b0;
	logic thermal_stage_one_in = 1'b0, thermal_stage_two_in = 1'b0, failsafe_in = 1'b0;
	logic timer1_in = 1'b0, timer2_in = 1'b0;
	logic [4:0] overcurrent_in = 5'h00, open_load_in = 5'h00, highside_outputs, e;
	logic [1:0] relay_outputs, thermal_state;
	logic [31:0] c1, c2, ov, mm;
	int err_total = 0, total_checks = 0, cyc = 0;

	opc_output_protection #(.RECOVER_CYC(3)) u_opc_output_protection (.pclk, .presetn, .paddr, .psel,
		.penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .supply_ov_in, .supply_uv_in,
		.overcurrent_in, .open_load_in, .thermal_warn_in, .thermal_stage_one_in, .thermal_stage_two_in,
		.standby_in, .failsafe_in, .timer1_in, .timer2_in, .highside_outputs, .relay_outputs,
		.lin_output_enable, .thermal_state);

	always #20 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			tally_and_finish();
		end
	end

	// ****
	// Bus and check tasks
	// ****
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// Pre-edge values are read right after the edge, before the design's updates land
	task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		// Release and let one edge pass, so a following call never reassigns psel in this step
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] x);
		xfer(a, 1'b0, 32'h0);
		chk(rd, x, "read");
	endtask
	// Releases the bus too, so a wait never leaves a request hanging
	task wt(input int n);
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (n) @(posedge pclk);
	endtask
	task hs_is(input logic [4:0] x);
		chk({27'h0, highside_outputs}, {27'h0, x}, "outputs");
	endtask
	task sup(input logic f, input logic lk, input logic rs);
		wr(CT, {30'h0, rs, lk});
		wt(4);
		supply_ov_in <= !f;
		supply_uv_in <= f;
		wt(5);
		hs_is(5'h00);
		chk({30'h0, relay_outputs}, rs ? 32'h0 : 32'h3, "relays");
		chk({31'h0, lin_output_enable}, 32'h0, "lin");
		supply_ov_in <= 1'b0;
		supply_uv_in <= 1'b0;
		wt(5);
		if (lk) begin
			hs_is(5'h00);
			rdc(SU, {30'h0, f, !f});
			wt(5);
		end
		hs_is(5'h1B);
		chk({30'h0, relay_outputs}, 32'h3, "relays back");
		chk({31'h0, lin_output_enable}, 32'h1, "lin back");
		rdc(SU, 32'h0);
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ****
	// Main sequence
	// ****
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rdc(CT, {28'h0, opc_pkg::CTRL4_RST});
		rdc(OC, {18'h0, opc_pkg::OUTCTL_RST});
		xfer(8'h1C, 1'b0, 32'h0);
		chk({31'h0, er}, 32'h1, "unmapped err");
		chk(rd, 32'h0, "unmapped data");
		$display("test reset done");
		for (int s = 0; s < 4; s++) begin
			wr(OC, 32'h0000071F | (32'(s) << 12));
			for (int t = 0; t < 4; t++) begin
				timer1_in <= t[0];
				timer2_in <= t[1];
				wt(4);
				e = {(s == 2) ? t[0] : (s == 3) ? t[1] : 1'b0, t[1], 1'b0, t[1], t[0]};
				hs_is(e);
			end
		end
		$display("test sources done");
		wr(opc_pkg::ADDR_PWMDUTY, 32'h40404040);
		wr(OC, 32'h0000001F);
		wt(260);
		c1 = 32'h0; c2 = 32'h0; ov = 32'h0; mm = 32'h0;
		repeat (512) begin
			@(posedge pclk);
			c1 += 32'(highside_outputs[0]);
			c2 += 32'(highside_outputs[1]);
			ov += 32'(highside_outputs[0] & highside_outputs[1]);
			mm += 32'(highside_outputs[0] !== highside_outputs[2] || highside_outputs[1] !== highside_outputs[3]);
		end
		chk(c1, 32'h80, "pwm1 on count");
		chk(c2, 32'h80, "pwm2 on count");
		chk(ov, 32'h0, "pwm overlap");
		chk(mm, 32'h0, "pwm pair phase");
		wr(opc_pkg::ADDR_PWMDUTY, 32'h0);
		wr(OC, ON);
		$display("test pwm done");
		sup(1'b0, 1'b0, 1'b1);
		sup(1'b1, 1'b1, 1'b1);
		sup(1'b0, 1'b1, 1'b0);
		sup(1'b1, 1'b0, 1'b0);
		$display("test supply done");
		overcurrent_in <= 5'h01;
		open_load_in <= 5'h02;
		wt(5);
		hs_is(5'h1A);
		overcurrent_in <= 5'h00;
		wt(5);
		hs_is(5'h1A);
		rdc(DS, 32'h00020001);
		open_load_in <= 5'h00;
		wt(4);
		wr(DS, 32'h00020001);
		wt(5);
		hs_is(5'h1B);
		rdc(DS, 32'h0);
		wr(CT, 32'h4);
		overcurrent_in <= 5'h10;
		wt(5);
		hs_is(5'h0B);
		rdc(DS, 32'h0);
		overcurrent_in <= 5'h00;
		wt(10);
		hs_is(5'h1B);
		overcurrent_in <= 5'h10;
		wt(5);
		wr(CT, 32'h0);
		wt(3);
		overcurrent_in <= 5'h00;
		wt(5);
		hs_is(5'h0B);
		rdc(DS, 32'h10);
		wr(DS, 32'h10);
		wt(5);
		hs_is(5'h1B);
		rdc(opc_pkg::ADDR_OUTSTATE, 32'h000000FB);
		$display("test overload done");
		thermal_warn_in <= 1'b1;
		wt(5);
		chk({30'h0, thermal_state}, 32'h1, "warning");
		hs_is(5'h1B);
		thermal_stage_one_in <= 1'b1;
		wt(6);
		chk({30'h0, thermal_state}, 32'h3, "stage one");
		hs_is(5'h00);
		thermal_stage_two_in <= 1'b1;
		wt(5);
		chk({30'h0, thermal_state}, 32'h2, "stage two");
		standby_in <= 1'b1;
		wt(5);
		thermal_stage_one_in <= 1'b0;
		thermal_stage_two_in <= 1'b0;
		thermal_warn_in <= 1'b0;
		wt(5);
		chk({30'h0, thermal_state}, 32'h2, "frozen");
		rdc(opc_pkg::ADDR_THERM, 32'h6);
		standby_in <= 1'b0;
		seen = 1'b0;
		repeat (8) begin
			@(posedge pclk);
			seen = seen | (thermal_state === 2'b11);
		end
		chk({31'h0, seen}, 32'h1, "resume stage one");
		wt(5);
		chk({30'h0, thermal_state}, 32'h0, "normal");
		wr(DS, 32'h00001F00);
		wt(5);
		hs_is(5'h1B);
		$display("test thermal done");
		for (int m = 0; m < 2; m++) begin
			wr(CT, m ? 32'h8 : 32'h0);
			wr(OC, ON);
			failsafe_in <= 1'b1;
			wt(5);
			hs_is(5'h00);
			failsafe_in <= 1'b0;
			wt(5);
			rdc(OC, m ? 32'h4 : 32'h0);
			hs_is(5'h00);
		end
		$display("test failsafe done");
		tally_and_finish();
	end
endmodule

bind opc_output_protection opc_protect_chk u_opc_protect_chk (.pclk, .presetn, .psel, .penable, .pready,
	.pslverr, .supply_ov_in, .supply_uv_in, .overcurrent_in, .thermal_stage_one_in, .standby_in,
	.highside_outputs, .lin_output_enable, .thermal_state);
